// ### rtl/attr_palette_pkg.sv
// shared constants for the attribute palette controller
package attr_palette_pkg;

  // ==========================================================
  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 1;
  localparam int COLOR_W = 6;
  localparam int NIB_W = 4;
  localparam int PAL_DEPTH = 16;
  localparam int PTR_W = 5;
  localparam int AREG_W = 6;
  localparam int MODE_W = 4;
  localparam int PEN_W = 6;
  localparam int PAN_W = 4;
  localparam int SYNC_W = 4;

  // ==========================================================
  // host port decode
  localparam logic [ADDR_W-1:0] PORT_ADDR = 1'h0;

  // ==========================================================
  // data register pointers
  localparam logic [PTR_W-1:0] PTR_MODE = 5'h10;
  localparam logic [PTR_W-1:0] PTR_OVERSCAN = 5'h11;
  localparam logic [PTR_W-1:0] PTR_PLANE_EN = 5'h12;
  localparam logic [PTR_W-1:0] PTR_PAN = 5'h13;

  // ==========================================================
  // field positions
  localparam int AREG_DISPLAY_BIT = 5;
  localparam int MODE_GFX_BIT = 0;
  localparam int PEN_MUX_LO = 4;
  localparam int STAT_DE_N_BIT = 0;
  localparam int STAT_VRTC_BIT = 3;
  localparam int STAT_DIAG4_BIT = 4;
  localparam int STAT_DIAG5_BIT = 5;

  // colour bit order inside a palette entry
  localparam int COL_B = 0;
  localparam int COL_G = 1;
  localparam int COL_R = 2;
  localparam int COL_SB = 3;
  localparam int COL_SG = 4;
  localparam int COL_SR = 5;

  // synchroniser lane positions
  localparam int SY_PIX = 0;
  localparam int SY_LOAD = 1;
  localparam int SY_DE = 2;
  localparam int SY_VRTC = 3;

  // ==========================================================
  // character timing and reset values
  localparam logic [2:0] DOTS_LAST = 3'h7;
  localparam logic [COLOR_W-1:0] COLOR_RST = 6'h00;
  localparam logic [AREG_W-1:0] AREG_RST = 6'h00;
  localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
  localparam logic [PEN_W-1:0] PEN_RST = 6'h0F;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;

endpackage

// ### rtl/attribute_palette_ctrl.sv
// attribute controller colour path with host register port
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps

// Contract
// - sixteen colours out of sixty-four
// - sixteen six-bit host-loadable palette entries
// - four-bit index picks one palette entry
// - text mode picks low or high nibble
// - code bit 1 low nibble, 0 high
// - graphics mode ignores condition code bits
// - graphics mode uses only low nibble
// - attribute inputs sampled on pixel clock
// - condition byte captured on load strobe
// - any read of the port address clears address/data select flop
// - every write to the port address toggles the select flop; a read in the same cycle clears it instead
// - read returns four-bit status on bus
// - six colour outputs, three primary, three secondary
// - entry bits 0-5 map B,G,R,SB,SG,SR
// - address bit5 0 loads, 1 displays
// - mode bit0 0 text, 1 graphics
module attribute_palette_ctrl (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [attr_palette_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [attr_palette_pkg::DATA_W-1:0] WR_DATA_IN,
  input wire logic WR_STROBE_IN,
  input wire logic RD_STROBE_IN,
  output logic [attr_palette_pkg::DATA_W-1:0] RD_DATA_OUT,
  input wire logic PIXEL_CLOCK_IN,
  input wire logic SEL_LOAD_IN,
  input wire logic [attr_palette_pkg::DATA_W-1:0] ATTR_BYTE_IN,
  input wire logic [attr_palette_pkg::DATA_W-1:0] COND_CODE_IN,
  input wire logic DISP_ENABLE_IN,
  input wire logic VRETRACE_IN,
  output logic BLUE_OUT,
  output logic GREEN_OUT,
  output logic RED_OUT,
  output logic SECONDARY_BLUE_MONO_OUT,
  output logic SECONDARY_GREEN_INTENSITY_OUT,
  output logic SECONDARY_RED_OUT
);
  import attr_palette_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [SYNC_W-1:0] pins;
  wire [SYNC_W-1:0] lvl;
  wire [SYNC_W-1:0] rise;
  logic [DATA_W-1:0] attr1_r;
  logic [DATA_W-1:0] attr2_r;
  logic [DATA_W-1:0] attr3_r;
  logic [DATA_W-1:0] cc1_r;
  logic [DATA_W-1:0] cc2_r;
  logic [DATA_W-1:0] cc3_r;

  assign pins = {VRETRACE_IN, DISP_ENABLE_IN, SEL_LOAD_IN, PIXEL_CLOCK_IN};

  genvar gs;
  generate
    for (gs = 0; gs < SYNC_W; gs++) begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      // a level counts only once stages two and three agree
      wire agree = (s2_r == s3_r);
      assign rise[gs] = agree && s2_r && !lvl_r;
      assign lvl[gs] = lvl_r;
      always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          lvl_r <= 1'b0;
        end else begin
          s1_r <= pins[gs];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // a lone disagreeing sample is a settling flop, not a change
          if (agree) begin
            lvl_r <= s2_r;
          end
        end
      end
    end
  endgenerate

  // data buses follow the strobes through the same depth
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      attr1_r <= BYTE_RST;
      attr2_r <= BYTE_RST;
      attr3_r <= BYTE_RST;
      cc1_r <= BYTE_RST;
      cc2_r <= BYTE_RST;
      cc3_r <= BYTE_RST;
    end else begin
      attr1_r <= ATTR_BYTE_IN;
      attr2_r <= attr1_r;
      attr3_r <= attr2_r;
      cc1_r <= COND_CODE_IN;
      cc2_r <= cc1_r;
      cc3_r <= cc2_r;
    end
  end

  wire pix_edge = rise[SY_PIX];
  wire load_edge = rise[SY_LOAD];

  // ==========================================================
  // host port decode
  logic sel_data_r;
  logic [AREG_W-1:0] areg_r;
  logic [MODE_W-1:0] mode_r;
  logic [COLOR_W-1:0] overscan_r;
  logic [PEN_W-1:0] plane_en_r;
  logic [PAN_W-1:0] pan_r;
  logic [COLOR_W-1:0] palette_r [PAL_DEPTH];
  logic [DATA_W-1:0] rd_data_r;

  wire hit = (ADDR_IN == PORT_ADDR);
  wire wr_hit = WR_STROBE_IN && hit;
  wire rd_hit = RD_STROBE_IN && hit;
  wire [PTR_W-1:0] ptr = areg_r[PTR_W-1:0];
  wire display_on = areg_r[AREG_DISPLAY_BIT];
  wire wr_data = wr_hit && sel_data_r;
  wire wr_addr = wr_hit && !sel_data_r;
  wire ptr_is_pal = (ptr[PTR_W-1] == 1'b0);
  // palette loads only while the display path is off it
  wire pal_we = wr_data && ptr_is_pal && !display_on;
  wire graphics = mode_r[MODE_GFX_BIT];
  // entry under the pointer; a data write never moves the pointer
  wire [COLOR_W-1:0] pal_at_ptr = palette_r[ptr[NIB_W-1:0]];

  // read clears, write toggles; a read in the same cycle as a write wins
  wire sel_data_nxt = rd_hit ? 1'b0 : (wr_hit ? !sel_data_r : sel_data_r);

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sel_data_r <= 1'b0;
    end else begin
      sel_data_r <= sel_data_nxt;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      areg_r <= AREG_RST;
    end else if (wr_addr) begin
      areg_r <= WR_DATA_IN[AREG_W-1:0];
    end
  end

  // undefined pointers fall through the case and are dropped
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mode_r <= MODE_RST;
      overscan_r <= COLOR_RST;
      plane_en_r <= PEN_RST;
      pan_r <= MODE_RST;
    end else if (wr_data) begin
      case (ptr)
        PTR_MODE: mode_r <= WR_DATA_IN[MODE_W-1:0];
        PTR_OVERSCAN: overscan_r <= WR_DATA_IN[COLOR_W-1:0];
        PTR_PLANE_EN: plane_en_r <= WR_DATA_IN[PEN_W-1:0];
        PTR_PAN: pan_r <= WR_DATA_IN[PAN_W-1:0];
        default: ;
      endcase
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < PAL_DEPTH; gp++) begin : g_pal
      always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          palette_r[gp] <= COLOR_RST;
        end else if (pal_we && (ptr[NIB_W-1:0] == NIB_W'(gp))) begin
          palette_r[gp] <= WR_DATA_IN[COLOR_W-1:0];
        end
      end
    end
  endgenerate

  // ==========================================================
  // condition code walk
  logic [DATA_W-1:0] cc_r;
  logic [2:0] cc_bit_r;
  logic [2:0] dot_r;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cc_r <= BYTE_RST;
      cc_bit_r <= 3'h0;
      dot_r <= 3'h0;
    end else if (load_edge) begin
      cc_r <= cc3_r;
      cc_bit_r <= 3'h0;
      dot_r <= 3'h0;
    end else if (pix_edge) begin
      dot_r <= dot_r + 3'h1;
      if (dot_r == DOTS_LAST) begin
        cc_bit_r <= cc_bit_r + 3'h1;
      end
    end
  end

  // ==========================================================
  // index select and palette lookup
  logic [NIB_W-1:0] idx_r;
  logic [COLOR_W-1:0] color_r;

  wire [NIB_W-1:0] low_nib = attr3_r[NIB_W-1:0];
  wire [NIB_W-1:0] high_nib = attr3_r[DATA_W-1:NIB_W];
  wire cc_sel = cc_r[cc_bit_r];
  // graphics ignores the code byte and the high nibble
  wire [NIB_W-1:0] idx_nxt = (graphics || cc_sel) ? low_nib : high_nib;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      idx_r <= 4'h0;
    end else if (pix_edge) begin
      idx_r <= idx_nxt;
    end
  end

  // blanked while the host owns the palette, to avoid torn colours
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      color_r <= COLOR_RST;
    end else begin
      color_r <= display_on ? palette_r[idx_r] : COLOR_RST;
    end
  end

  assign BLUE_OUT = color_r[COL_B];
  assign GREEN_OUT = color_r[COL_G];
  assign RED_OUT = color_r[COL_R];
  assign SECONDARY_BLUE_MONO_OUT = color_r[COL_SB];
  assign SECONDARY_GREEN_INTENSITY_OUT = color_r[COL_SG];
  assign SECONDARY_RED_OUT = color_r[COL_SR];

  // ==========================================================
  // status port
  logic [1:0] diag;
  wire [1:0] mux_sel = plane_en_r[PEN_MUX_LO+1:PEN_MUX_LO];

  always_comb begin
    case (mux_sel)
      2'h0: diag = {color_r[COL_R], color_r[COL_B]};
      2'h1: diag = {color_r[COL_SB], color_r[COL_G]};
      2'h2: diag = {color_r[COL_SR], color_r[COL_SG]};
      default: diag = 2'h0;
    endcase
  end

  logic [DATA_W-1:0] status;
  always_comb begin
    status = BYTE_RST;
    status[STAT_DE_N_BIT] = !lvl[SY_DE];
    status[STAT_VRTC_BIT] = lvl[SY_VRTC];
    status[STAT_DIAG4_BIT] = diag[0];
    status[STAT_DIAG5_BIT] = diag[1];
  end

  // data stand only in the cycle after the read
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rd_data_r <= BYTE_RST;
    end else begin
      rd_data_r <= rd_hit ? status : BYTE_RST;
    end
  end

  assign RD_DATA_OUT = rd_data_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  a_write_toggles: assert property (wr_hit |=> sel_data_r != $past(sel_data_r))
    else $error("select flop did not toggle on write");
  a_read_clears: assert property (rd_hit |=> !sel_data_r)
    else $error("select flop not cleared by read");
  a_addr_load: assert property (wr_addr |=> areg_r == $past(WR_DATA_IN[AREG_W-1:0]))
    else $error("address register not loaded");
  a_palette_store: assert property (pal_we |=> pal_at_ptr == $past(WR_DATA_IN[COLOR_W-1:0]))
    else $error("palette entry not stored");
  a_palette_guard: assert property (wr_data && display_on |=> $stable(pal_at_ptr))
    else $error("palette changed while displayed");
  a_undef_ignored: assert property (wr_data && ptr > PTR_PAN |=> $stable(mode_r) && $stable(plane_en_r))
    else $error("undefined pointer changed a register");
  a_status_read: assert property (rd_hit |=> RD_DATA_OUT == $past(status))
    else $error("status not returned after read");
  a_graphics_low: assert property (pix_edge && graphics |=> idx_r == $past(low_nib))
    else $error("graphics index not low nibble");
  a_text_fore: assert property (pix_edge && !graphics && cc_sel |=> idx_r == $past(low_nib))
    else $error("foreground nibble not chosen");
  a_text_back: assert property (pix_edge && !graphics && !cc_sel |=> idx_r == $past(high_nib))
    else $error("background nibble not chosen");
  a_color_map: assert property (display_on ##1 display_on && $stable(idx_r)
    |-> color_r == palette_r[idx_r])
    else $error("colour does not match palette entry");
  a_cc_load: assert property (load_edge |=> cc_r == $past(cc3_r) && cc_bit_r == 3'h0)
    else $error("condition byte not loaded");

  // register port side effects
  a_read_idle: assert property (!rd_hit |=> RD_DATA_OUT == BYTE_RST)
    else $error("read data not idle without a read");
  a_unmapped_hold: assert property ((WR_STROBE_IN || RD_STROBE_IN) && !hit
    |=> $stable(sel_data_r))
    else $error("unmapped access moved the select flop");
  a_data_keeps_ptr: assert property (wr_data |=> $stable(areg_r))
    else $error("data write moved the address register");
  a_mode_load: assert property (wr_data && ptr == PTR_MODE
    |=> mode_r == $past(WR_DATA_IN[MODE_W-1:0]))
    else $error("mode register not loaded");
  a_overscan_load: assert property (wr_data && ptr == PTR_OVERSCAN
    |=> overscan_r == $past(WR_DATA_IN[COLOR_W-1:0]))
    else $error("overscan register not loaded");

  // pixel path and code walk
  a_gfx_ignores_cc: assert property (pix_edge && graphics && !cc_sel |=> idx_r == $past(low_nib))
    else $error("graphics index followed the code bit");
  a_idx_hold: assert property (!pix_edge |=> $stable(idx_r))
    else $error("index moved without a pixel edge");
  a_code_hold: assert property (!load_edge |=> $stable(cc_r))
    else $error("code byte moved without a load");
  a_cc_step: assert property (pix_edge && !load_edge && dot_r == DOTS_LAST
    |=> cc_bit_r == $past(cc_bit_r) + 3'h1)
    else $error("code bit did not advance at character end");
  a_blank_off: assert property (!display_on |=> color_r == COLOR_RST)
    else $error("colour not blanked while host owns palette");

  c_text_pixel: cover property (pix_edge && !graphics ##1 display_on);
  c_text_back: cover property (pix_edge && !graphics && !cc_sel);
  c_gfx_pixel: cover property (pix_edge && graphics);
  c_pal_write: cover property (rd_hit ##1 wr_addr ##1 pal_we);
  c_char_step: cover property (pix_edge && dot_r == DOTS_LAST);

endmodule // attribute_palette_ctrl

// ### bench/pixel_feeder.sv
// far-side model: serializer and crt timing that feed the colour path
`timescale 1ns/10ps
module pixel_feeder (
  input wire logic clk_in,
  output logic pix_clk_out,
  output logic load_out,
  output logic [7:0] attr_out,
  output logic [7:0] code_out,
  output logic de_out,
  output logic vrtc_out
);
  // ==========================================
  // idle levels
  initial begin
    pix_clk_out = 1'b0;
    load_out = 1'b0;
    attr_out = 8'hA5;
    code_out = 8'h5A;
    de_out = 1'b1;
    vrtc_out = 1'b0;
  end

  // ==========================================
  // strobes: data set 4 clocks early, 3 high, 3 low, as the sync chain needs
  task automatic pulse(input bit is_load);
    repeat (4) @(posedge clk_in);
    if (is_load) load_out <= 1'b1;
    else pix_clk_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    load_out <= 1'b0;
    pix_clk_out <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic load_code(input logic [7:0] cc);
    @(posedge clk_in);
    code_out <= cc;
    pulse(1'b1);
    code_out <= ~cc; // released bus no longer holds the byte
  endtask

  task automatic pixel(input logic [7:0] a);
    @(posedge clk_in);
    attr_out <= a;
    pulse(1'b0);
    attr_out <= ~a;
  endtask

  task automatic set_lines(input logic de, input logic vr);
    @(posedge clk_in);
    de_out <= de;
    vrtc_out <= vr;
  endtask
endmodule // pixel_feeder

// ### bench/tb_attribute_palette_ctrl.sv
// self-checking bench for the attribute palette controller
`timescale 1ns/10ps
module tb_attribute_palette_ctrl;
  import attr_palette_pkg::*;
  typedef struct {logic [7:0] cc; logic [7:0] at; logic [3:0] idx;} row_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = PORT_ADDR;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic pix, ld, de, vr, b, g, r, sb, sg, sr;
  logic [7:0] attr, code, got;
  logic [5:0] col, c5;
  logic [1:0] dm;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  row_type rows [6] = '{'{8'h01, 8'h5A, 4'hA}, '{8'h00, 8'h5A, 4'h5}, '{8'hFE, 8'h3C, 4'h3},
    '{8'hFF, 8'hF0, 4'h0}, '{8'h80, 8'hE7, 4'hE}, '{8'h01, 8'h3F, 4'hF}};
  assign col = {sr, sg, sb, r, g, b};

  always #10 clk = ~clk;

  attribute_palette_ctrl dut (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WR_DATA_IN(wdata),
    .WR_STROBE_IN(wr), .RD_STROBE_IN(rd), .RD_DATA_OUT(rdata), .PIXEL_CLOCK_IN(pix), .SEL_LOAD_IN(ld),
    .ATTR_BYTE_IN(attr), .COND_CODE_IN(code), .DISP_ENABLE_IN(de), .VRETRACE_IN(vr), .BLUE_OUT(b),
    .GREEN_OUT(g), .RED_OUT(r), .SECONDARY_BLUE_MONO_OUT(sb), .SECONDARY_GREEN_INTENSITY_OUT(sg),
    .SECONDARY_RED_OUT(sr));
  pixel_feeder feeder (.clk_in(clk), .pix_clk_out(pix), .load_out(ld), .attr_out(attr), .code_out(code),
    .de_out(de), .vrtc_out(vr));

  // ==========================================
  // helpers
  function automatic logic [5:0] pal(input int i);
    return 6'((i * 5 + 3) % 64); // distinct for all sixteen entries
  endfunction

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= PORT_ADDR;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= PORT_ADDR;
    @(negedge clk);
    got = rdata;
  endtask

  task automatic show(input logic [7:0] at, input logic [5:0] e);
    feeder.pixel(at);
    repeat (2) @(negedge clk);
    chk("colour", {2'h0, e}, {2'h0, col});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // a few hundred cycles are expected; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    repeat (15) @(posedge clk);
    @(negedge clk);
    chk("reset colour", 8'h00, {2'h0, col});
    chk("reset read", 8'h00, rdata);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk("release colour", 8'h00, {2'h0, col});
    $display("test reset done");
    rd_reg(PORT_ADDR);
    for (int i = 0; i < 16; i++) begin
      wr_reg(PORT_ADDR, 8'(i));
      wr_reg(PORT_ADDR, {2'h0, pal(i)});
    end
    wr_reg(PORT_ADDR, 8'h10);
    wr_reg(PORT_ADDR, 8'h00);
    wr_reg(1'h1, 8'h00); // unmapped, leaves the select flop alone
    wr_reg(PORT_ADDR, 8'h20);
    foreach (rows[k]) begin
      feeder.load_code(rows[k].cc);
      show(rows[k].at, pal(rows[k].idx));
    end
    $display("test table done");
    feeder.load_code(8'h02);
    for (int p = 0; p < 9; p++) show(8'h21, pal(p < 8 ? 2 : 1));
    $display("test character count done");
    rd_reg(PORT_ADDR);
    wr_reg(PORT_ADDR, 8'h30);
    wr_reg(PORT_ADDR, 8'h01);
    feeder.load_code(8'h00);
    show(8'hF5, pal(5));
    $display("test graphics done");
    c5 = pal(5);
    for (int s = 0; s < 4; s++) begin
      dm = (s == 0) ? {c5[COL_R], c5[COL_B]} : (s == 1) ? {c5[COL_SB], c5[COL_G]} :
        (s == 2) ? {c5[COL_SR], c5[COL_SG]} : 2'h0;
      feeder.set_lines(s[0], s[1]);
      rd_reg(PORT_ADDR);
      wr_reg(PORT_ADDR, 8'h32);
      wr_reg(PORT_ADDR, {2'h0, 2'(s), 4'hF});
      rd_reg(PORT_ADDR);
      chk("status", {2'h0, dm, s[1], 2'h0, ~s[0]}, got);
      @(negedge clk);
      chk("read idle", 8'h00, rdata);
    end
    rd_reg(1'h1);
    chk("unmapped read", 8'h00, got);
    $display("test status done");
    rd_reg(PORT_ADDR);
    wr_reg(PORT_ADDR, 8'h34);
    wr_reg(PORT_ADDR, 8'h00); // undefined pointer, dropped
    wr_reg(PORT_ADDR, 8'h20);
    wr_reg(PORT_ADDR, 8'h3F); // palette write refused while displaying
    show(8'h50, pal(0));
    wr_reg(PORT_ADDR, 8'h20);
    rd_reg(PORT_ADDR);
    wr_reg(PORT_ADDR, 8'h00);
    show(8'h05, 6'h00);
    $display("test refusals done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(negedge clk);
    chk("second reset", 8'h00, {2'h0, col});
    @(posedge clk);
    rst <= 1'b0;
    wr_reg(PORT_ADDR, 8'h01); // reset leaves the flop in address state
    wr_reg(PORT_ADDR, 8'h2A);
    wr_reg(PORT_ADDR, 8'h21);
    show(8'h11, 6'h2A);
    $display("test second reset done");
    summarize();
  end
endmodule // tb_attribute_palette_ctrl
